/* core/msr_regs.sv */
`timescale 1ns/1ps
`include "msr_defines.svh"
module msr_regs (
   input wire logic clk_i,                  // 50 MHz clock
   input wire logic rstn_i,                 // sync reset, active low
   input wire msr_pkg::msr_cmd_s cmd_i,     // decoded serial command
   input wire logic [11:0] speed_a_i,       // speed input one level
   input wire logic [11:0] speed_b_i,       // speed input two level
   input wire logic [11:0] cur_a_i,         // motor one load current
   input wire logic [11:0] cur_b_i,         // motor two load current
   input wire logic [11:0] serial_a_i,      // serial speed, motor one
   input wire logic [11:0] serial_b_i,      // serial speed, motor two
   input wire logic [11:0] supply_i,        // supply voltage level
   input wire logic [11:0] off_max_i,       // turn-off maximum value
   input wire logic [11:0] on_min_i,        // turn-on minimum value
   input wire logic top_en_i,               // supply compensation enable
   input wire logic heat_i,                 // over-temperature
   input wire logic [3:0] motion_i,         // b rev, b fwd, a rev, a fwd
   input wire logic [1:0] brake_i,          // b, a brake mode
   input wire logic [1:0] heading_pin_i,    // async pins b, a
   output msr_pkg::msr_rsp_s rsp_o,         // answer, registered
   output logic [11:0] drive_a_o,           // motor one output level
   output logic [11:0] drive_b_o,           // motor two output level
   output logic [3:0] knob_lock_o           // lock bits to knob logic
);
   // complete register state and its next value
   msr_pkg::msr_state_s st;
   msr_pkg::msr_state_s next_st;
   // write value rebuilt from the two bytes
   logic [13:0] wr_val;
   // read value before it is split
   logic [13:0] rd_val;
   // code recognised
   logic known;

   // knob-to-output path for one motor
   function automatic logic [11:0] msr_drive(
      input logic [11:0] level,
      input logic [11:0] serial,
      input logic velo_lock,
      input logic [11:0] flr,
      input logic [11:0] ceil,
      input logic [11:0] top,
      input logic comp_en,
      input logic [11:0] supply,
      input logic [13:0] irc,
      input logic [11:0] cur
   );
      logic [11:0] pct;
      logic [11:0] span;
      logic [23:0] scaled;
      logic [23:0] ref_v;
      logic [25:0] gain;
      logic [12:0] sum;
      logic [11:0] base;
      pct = 12'h000;
      span = ceil - flr;
      scaled = 24'h000000;
      // locked input is free for other uses; serial value drives
      if (velo_lock) begin
         pct = serial;
      end else if (level <= flr || ceil <= flr) begin
         pct = 12'h000;
      end else if (level >= ceil) begin
         pct = `MSR_FULL;
      end else begin
         scaled = ({12'h000, level - flr} * 24'(`MSR_FULL)) / {12'h000, span};
         pct = scaled[11:0];
      end
      // ceiling acts as full-scale reference for the command
      ref_v = ({12'h000, pct} * {12'h000, top}) >> 12;
      base = ref_v[11:0];
      // compensation turns a target voltage into duty by supply
      if (comp_en && supply != 12'h000) begin
         ref_v = ({12'h000, base} * 24'(`MSR_FULL)) / {12'h000, supply};
         base = (ref_v > 24'(`MSR_FULL)) ? `MSR_FULL : ref_v[11:0];
      end
      // resistance drop made up from measured current
      gain = ({12'h000, irc} * {14'h0000, cur}) >> `MSR_IRC_SHIFT;
      sum = {1'b0, base} + {1'b0, gain[11:0]};
      if (gain[25:12] != 14'h0000 || sum[12]) begin
         sum = {1'b0, `MSR_FULL}; // saturate rather than wrap
      end
      // near-zero ceiling means no output at all
      if (top < `MSR_TOP_ZERO_BAND) begin
         sum = 13'h0000;
      end
      return sum[11:0];
   endfunction

   // value bits 13..7 in the first byte, 6..0 in the second
   assign wr_val = {cmd_i.hi, cmd_i.lo};

   // read decode: measurements come live from the inputs
   always_comb begin
      rd_val = 14'h0000;
      known = 1'b1;
      unique case (cmd_i.code)
         `MSR_RD_SPEED_A: rd_val = {2'b00, speed_a_i};
         `MSR_RD_SPEED_B: rd_val = {2'b00, speed_b_i};
         `MSR_RD_CUR_A: rd_val = {2'b00, cur_a_i};
         `MSR_RD_CUR_B: rd_val = {2'b00, cur_b_i};
         `MSR_RD_IRC: rd_val = st.resistance_compensation;
         `MSR_RD_TOP: rd_val = {2'b00, st.output_ceiling};
         `MSR_RD_FLOOR: rd_val = {2'b00, st.input_floor_level};
         `MSR_RD_CEIL: rd_val = {2'b00, st.input_ceiling_level};
         `MSR_RD_STATUS: rd_val = st.controller_state_flags;
         `MSR_RD_LOCK: rd_val = {10'h000, st.knob_override_locks};
         `MSR_WR_IRC, `MSR_WR_TOP, `MSR_WR_FLOOR, `MSR_WR_CEIL,
         `MSR_WR_LOCK: rd_val = 14'h0000;                            // writes answer zero
         default: known = 1'b0; // any other code, incl. writes to read-only
      endcase
   end

   // next-state logic for the whole block
   always_comb begin
      next_st = st;
      // pins pass two flops; only the second stage is read
      next_st.pin_meta = heading_pin_i;
      next_st.pin_sync = st.pin_meta;
      // status snapshot each cycle
      next_st.controller_state_flags = '0;
      next_st.controller_state_flags.motor_b_reverse_flag = motion_i[3];
      next_st.controller_state_flags.motor_b_forward_flag = motion_i[2];
      next_st.controller_state_flags.motor_a_reverse_flag = motion_i[1];
      next_st.controller_state_flags.motor_a_forward_flag = motion_i[0];
      next_st.controller_state_flags.heading_pin_b_level = st.pin_sync[1];
      next_st.controller_state_flags.heading_pin_a_level = st.pin_sync[0];
      next_st.controller_state_flags.motor_b_brake_flag = brake_i[1];
      next_st.controller_state_flags.motor_a_brake_flag = brake_i[0];
      next_st.controller_state_flags.heat_flag = heat_i;
      next_st.controller_state_flags.supply_high_flag = supply_i > off_max_i;
      next_st.controller_state_flags.supply_low_flag = supply_i < on_min_i;
      // answer strobe lasts one cycle
      next_st.rsp = '0;
      if (cmd_i.valid) begin
         next_st.rsp.valid = 1'b1;
         next_st.rsp.ack = known;
         next_st.rsp.hi = rd_val[13:7];
         next_st.rsp.lo = rd_val[6:0];
         // only writable codes store; read-only values cannot be hit
         unique case (cmd_i.code)
            `MSR_WR_IRC: next_st.resistance_compensation = wr_val;
            `MSR_WR_TOP: next_st.output_ceiling = wr_val[11:0];
            `MSR_WR_FLOOR: next_st.input_floor_level = wr_val[11:0];
            `MSR_WR_CEIL: next_st.input_ceiling_level = wr_val[11:0];
            `MSR_WR_LOCK: next_st.knob_override_locks = wr_val[3:0];
            default: ; // reads and unknown codes store nothing
         endcase
      end
      // output levels from knobs or serial speed
      next_st.drive_a = msr_drive(speed_a_i, serial_a_i,
         st.knob_override_locks[`MSR_LOCK_VELO], st.input_floor_level,
         st.input_ceiling_level, st.output_ceiling, top_en_i, supply_i,
         st.resistance_compensation, cur_a_i);
      next_st.drive_b = msr_drive(speed_b_i, serial_b_i,
         st.knob_override_locks[`MSR_LOCK_VELO], st.input_floor_level,
         st.input_ceiling_level, st.output_ceiling, top_en_i, supply_i,
         st.resistance_compensation, cur_b_i);
   end

   // state register; restart clears locks and loads the tuning reset values
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st <= '0;
         st.resistance_compensation <= `MSR_IRC_RST;
         st.output_ceiling <= `MSR_TOP_RST;
         st.input_floor_level <= `MSR_FLOOR_RST;
         st.input_ceiling_level <= `MSR_CEIL_RST;
         st.knob_override_locks <= `MSR_LOCK_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign rsp_o = st.rsp;
   assign drive_a_o = st.drive_a;
   assign drive_b_o = st.drive_b;
   assign knob_lock_o = st.knob_override_locks;
endmodule // msr_regs

/* core/msr_defines.svh */
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH
// read command codes
`define MSR_RD_SPEED_A 8'h11
`define MSR_RD_CUR_A 8'h12
`define MSR_RD_CUR_B 8'h13
`define MSR_RD_SPEED_B 8'h14
`define MSR_RD_IRC 8'h20
`define MSR_RD_TOP 8'h21
`define MSR_RD_FLOOR 8'h22
`define MSR_RD_CEIL 8'h23
`define MSR_RD_STATUS 8'h30
`define MSR_RD_LOCK 8'h31
// write command codes
`define MSR_WR_IRC 8'h60
`define MSR_WR_TOP 8'h61
`define MSR_WR_FLOOR 8'h62
`define MSR_WR_CEIL 8'h63
`define MSR_WR_LOCK 8'h71
// lock bit positions
`define MSR_LOCK_VELO 0
`define MSR_LOCK_LIMIT 1
`define MSR_LOCK_REGEN 2
`define MSR_LOCK_RAMP 3
// reset values
`define MSR_IRC_RST 14'h0000
`define MSR_TOP_RST 12'hfff
`define MSR_FLOOR_RST 12'h000
`define MSR_CEIL_RST 12'hfff
`define MSR_LOCK_RST 4'h0
// scaling
`define MSR_FULL 12'hfff
`define MSR_TOP_ZERO_BAND 12'h008
`define MSR_IRC_SHIFT 14
`endif

/* core/msr_pkg.sv */
package msr_pkg;
   // one serial command, already split into its two data bytes
   typedef struct packed {
      logic valid;      // one-cycle strobe
      logic [7:0] code; // command code
      logic [6:0] hi;   // value bits 13..7
      logic [6:0] lo;   // value bits 6..0
   } msr_cmd_s;
   // answer to one command
   typedef struct packed {
      logic valid;      // one-cycle strobe
      logic ack;        // code known
      logic [6:0] hi;   // value bits 13..7
      logic [6:0] lo;   // value bits 6..0
   } msr_rsp_s;
   // status word, bit 13 first
   typedef struct packed {
      logic rsv13;
      logic motor_b_reverse_flag;
      logic motor_b_forward_flag;
      logic motor_a_reverse_flag;
      logic motor_a_forward_flag;
      logic heading_pin_b_level;
      logic heading_pin_a_level;
      logic rsv6;
      logic motor_b_brake_flag;
      logic motor_a_brake_flag;
      logic rsv3;
      logic heat_flag;
      logic supply_high_flag;
      logic supply_low_flag;
   } msr_status_s;
   // every flip-flop of the block
   typedef struct packed {
      logic [1:0] pin_meta;  // first sync stage
      logic [1:0] pin_sync;  // second sync stage
      logic [13:0] resistance_compensation;
      logic [11:0] output_ceiling;
      logic [11:0] input_floor_level;
      logic [11:0] input_ceiling_level;
      logic [3:0] knob_override_locks;
      msr_status_s controller_state_flags;
      msr_rsp_s rsp;
      logic [11:0] drive_a;
      logic [11:0] drive_b;
   } msr_state_s;
endpackage : msr_pkg

/* dv/msr_regs_properties.sv */
`timescale 1ns/1ps
module msr_regs_properties (
   input wire logic clk_i,                // bench clock
   input wire logic rstn_i,               // sync reset, low
   input wire msr_pkg::msr_cmd_s cmd_i,   // serial command
   input wire logic [11:0] speed_a_i,     // speed input one
   input wire logic [11:0] cur_a_i,       // load current one
   input wire logic heat_i,               // over-temperature
   input wire msr_pkg::msr_rsp_s rsp_o,   // answer
   input wire logic [3:0] knob_lock_o     // lock bits
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // code has a meaning to the block
   logic known;
   always_comb known = cmd_i.code inside {8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h21, 8'h22, 8'h23,
      8'h30, 8'h31, 8'h60, 8'h61, 8'h62, 8'h63, 8'h71};
   // steps of a command and of a write followed by its read
   sequence s_cmd(c);
      cmd_i.valid && cmd_i.code == c;
   endsequence
   sequence s_top_wr_rd;
      s_cmd(8'h61) ##1 s_cmd(8'h21);
   endsequence
   a_rsp_one_cycle: assert property (1'b1 |=> rsp_o.valid == $past(cmd_i.valid))
      else $error("answer strobe not one cycle after command");
   a_top_round_trip: assert property (s_top_wr_rd |=> {rsp_o.hi, rsp_o.lo} ==
      {2'b00, $past(cmd_i.hi[4:0], 2), $past(cmd_i.lo, 2)}) else $error("ceiling read differs");
   a_speed_a_read: assert property (s_cmd(8'h11) |=> {rsp_o.hi, rsp_o.lo} == {2'b00, $past(speed_a_i)})
      else $error("speed level read wrong");
   a_load_a_read: assert property (s_cmd(8'h12) |=> {rsp_o.hi, rsp_o.lo} == {2'b00, $past(cur_a_i)})
      else $error("load current read wrong");
   a_lock_write_lands: assert property (s_cmd(8'h71) |=> knob_lock_o == $past(cmd_i.lo[3:0]))
      else $error("lock bits not stored");
   a_lock_reset_clear: assert property (rstn_i && !$past(rstn_i) |-> knob_lock_o == 4'h0)
      else $error("lock bits survive reset");
   a_unknown_refused: assert property (cmd_i.valid && !known |=> !rsp_o.ack && rsp_o.hi == 7'h00
      && rsp_o.lo == 7'h00) else $error("unknown code not refused");
   a_known_acked: assert property (cmd_i.valid && known |=> rsp_o.ack)
      else $error("known code refused");
   a_heat_status: assert property (cmd_i.valid && cmd_i.code == 8'h30 && $past(rstn_i)
      |=> rsp_o.lo[2] == $past(heat_i, 2)) else $error("heat flag wrong");
endmodule // msr_regs_properties
bind msr_regs msr_regs_properties msr_regs_properties_inst (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
   .speed_a_i(speed_a_i), .cur_a_i(cur_a_i), .heat_i(heat_i), .rsp_o(rsp_o), .knob_lock_o(knob_lock_o));

/* dv/msr_host_model.sv */
`timescale 1ns/1ps
module msr_host_model (
   input wire logic clk_i,                // bench clock
   output msr_pkg::msr_cmd_s cmd_o,       // command to the block
   input wire msr_pkg::msr_rsp_s rsp_i    // answer from the block
);
   // idle until the first request
   initial cmd_o = '0;
   // one command; answer is taken one edge after the command edge
   task automatic xfer(input logic [7:0] code, input logic [13:0] val, output msr_pkg::msr_rsp_s r);
      @(posedge clk_i) #1;
      cmd_o = {1'b1, code, val[13:7], val[6:0]};
      @(posedge clk_i) #1;
      cmd_o = '0;
      r = rsp_i;
   endtask
   // write then read on the very next edge; answer of the read returned
   task automatic pair(input logic [7:0] c1, input logic [13:0] v1, input logic [7:0] c2,
      output msr_pkg::msr_rsp_s r);
      @(posedge clk_i) #1;
      cmd_o = {1'b1, c1, v1[13:7], v1[6:0]};
      @(posedge clk_i) #1;
      cmd_o = {1'b1, c2, 14'h0000}; // back to back, no idle edge
      @(posedge clk_i) #1;
      cmd_o = '0;
      r = rsp_i;
   endtask
endmodule // msr_host_model

/* dv/msr_regs_tb.sv */
`timescale 1ns/1ps
module msr_regs_tb;
   logic clk_i = 1'b0;   // 50 MHz
   logic rstn_i = 1'b0;  // held low at start
   msr_pkg::msr_cmd_s cmd;
   msr_pkg::msr_rsp_s rsp;
   msr_pkg::msr_rsp_s r;
   logic [11:0] spd_a = 12'h123, spd_b = 12'hfed, cur_a = 12'h064, cur_b = 12'h9ab, ser_a = 12'h7d0;
   logic [11:0] supply = 12'h064, off_max = 12'h032, on_min = 12'h0c8;
   logic heat = 1'b1;
   logic top_en = 1'b0;  // supply compensation enable
   logic [3:0] motion = 4'h9;
   logic [1:0] brake = 2'h2, pins = 2'h1;
   logic [11:0] drv_a, drv_b;
   logic [3:0] locks;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   // write codes and values; read code is write code minus 0x40
   logic [7:0] wc [5] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h71};
   logic [13:0] wv [5] = '{14'h3fff, 14'h0438, 14'h034c, 14'h0b8c, 14'h000a};
   msr_regs msr_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd), .speed_a_i(spd_a), .speed_b_i(spd_b),
      .cur_a_i(cur_a), .cur_b_i(cur_b), .serial_a_i(ser_a), .serial_b_i(ser_a), .supply_i(supply),
      .off_max_i(off_max), .on_min_i(on_min), .top_en_i(top_en), .heat_i(heat), .motion_i(motion),
      .brake_i(brake), .heading_pin_i(pins), .rsp_o(rsp), .drive_a_o(drv_a), .drive_b_o(drv_b),
      .knob_lock_o(locks));
   msr_host_model msr_host_model_inst (.clk_i(clk_i), .cmd_o(cmd), .rsp_i(rsp));
   initial forever #10 clk_i = ~clk_i;
   // hang guard, well above the roughly 75 cycles used
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // read and compare the two data bytes
   task automatic rd(input logic [7:0] c, input logic [13:0] exp);
      msr_host_model_inst.xfer(c, 14'h0000, r);
      chk({r.hi, r.lo}, exp);
   endtask
   // write, expecting a valid acknowledge
   task automatic wr(input logic [7:0] c, input logic [13:0] v);
      msr_host_model_inst.xfer(c, v, r);
      chk({12'h000, r.valid, r.ack}, 14'h0003);
   endtask
   // drive output after settling, compared in place
   task automatic drv(input logic [11:0] exp);
      repeat (3) @(posedge clk_i);
      #1 chk({2'b00, drv_a}, {2'b00, exp});
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      rd(8'h31, 14'h0000);
      rd(8'h21, 14'h0fff);
      for (int i = 0; i < 5; i++) begin
         wr(wc[i], wv[i]);
         rd(wc[i] - 8'h40, wv[i]);
      end
      // write and read on adjacent edges, then restore ceiling 1080
      msr_host_model_inst.pair(8'h61, 14'h0123, 8'h21, r);
      chk({r.hi, r.lo}, 14'h0123);
      wr(8'h61, 14'h0438);
      rd(8'h11, 14'h0123);
      rd(8'h14, 14'h0fed);
      rd(8'h12, 14'h0064);
      rd(8'h13, 14'h09ab);
      // write to a read-only place must be refused
      msr_host_model_inst.xfer(8'h51, 14'h3fff, r);
      chk({r.ack, r.hi, r.lo[6:1]}, 14'h0000);
      rd(8'h11, 14'h0123);
      rd(8'h30, 14'h12a7);
      // limits stand as written in the loop; full-scale input, ceiling 1080, +25
      wr(8'h60, 14'h1000);
      spd_a = 12'hb8c;
      drv(12'h450);
      spd_a = 12'h34c;
      drv(12'h019);
      // serial speed replaces the input once locked
      wr(8'h71, 14'h0001);
      drv(12'h228);
      chk({2'b00, drv_b}, 14'h0479);
      chk({10'h000, locks}, 14'h0001);
      // supply compensation: 527 * 4095 / 2048 = 1053, plus 25
      supply = 12'h800;
      top_en = 1'b1;
      drv(12'h436);
      rd(8'h11, 14'h034c);
      wr(8'h61, 14'h0004);
      drv(12'h000);
      // reset in mid-run clears the locks
      rstn_i = 1'b0;
      @(posedge clk_i) #1;
      rstn_i = 1'b1;
      rd(8'h31, 14'h0000);
      tally_and_finish();
   end
endmodule // msr_regs_tb
